// ---- core/prom_prog_pkg.sv ----
// constants and types for the fuse prom programming sequencer
package prom_prog_pkg;
    // ************************************************************
    // widths
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int BIT_W = 3;
    localparam int CNT_W = 16;
    localparam int PULSE_W = 4;
    // ************************************************************
    // timing, clock 40 MHz
    // ************************************************************
    localparam int CLK_PERIOD_PS = 25000;
    localparam int STEP_DELAY_NS = 100;
    localparam int PULSE_WIDTH_NS = 10000;
    localparam int DUTY_PERCENT = 25;
    localparam int STEP_CYCLES_I = (STEP_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PULSE_CYCLES_I = (PULSE_WIDTH_NS * 1000) / CLK_PERIOD_PS;
    // elevated supply time is step + output step + pulse + fall; off time keeps it under a quarter
    localparam int HIGH_CYCLES_I = PULSE_CYCLES_I + 3 * STEP_CYCLES_I;
    localparam int COOL_CYCLES_I = HIGH_CYCLES_I * (100 - DUTY_PERCENT) / DUTY_PERCENT;
    localparam logic [CNT_W-1:0] STEP_CYCLES = CNT_W'(STEP_CYCLES_I);
    localparam logic [CNT_W-1:0] PULSE_CYCLES = CNT_W'(PULSE_CYCLES_I);
    localparam logic [CNT_W-1:0] COOL_CYCLES = CNT_W'(COOL_CYCLES_I);
    // ************************************************************
    // pulse counts
    // ************************************************************
    localparam logic [PULSE_W-1:0] MAX_PULSES = 4'h0_00A;
    localparam logic [PULSE_W-1:0] EXTRA_PULSES = 4'h0_005;
    // ************************************************************
    // supply level codes for the analog driver
    // ************************************************************
    typedef enum logic [1:0] {
        SUPPLY_NORMAL = 2'h0,
        SUPPLY_PROGRAM = 2'h1,
        SUPPLY_VERIFY_LOW = 2'h2,
        SUPPLY_VERIFY_HIGH = 2'h3
    } supply_level_t;
    // ************************************************************
    // sequencer states, one-hot
    // ************************************************************
    typedef enum logic [11:0] {
        ST_IDLE = 12'h0_001,
        ST_ADDR = 12'h0_002,
        ST_VCC_UP = 12'h0_004,
        ST_OUT_UP = 12'h0_008,
        ST_PULSE = 12'h0_010,
        ST_OUT_DN = 12'h0_020,
        ST_VCC_DN = 12'h0_040,
        ST_VFY_LO = 12'h0_080,
        ST_VFY_HI = 12'h0_100,
        ST_DECIDE = 12'h0_200,
        ST_COOL = 12'h0_400,
        ST_DONE = 12'h0_800
    } state_t;
endpackage

// ---- core/fuse_prom_program_sequencer.sv ----
// sequencer that blows one prom fuse bit per request and verifies it
// ************************************************************
// Overview of operation
// - per cycle: address while disabled, supply up, output up, enable pulse, back down.
// - only one output elevated per cycle, every other output left undriven.
// - at least 100 ns between consecutive sequence steps.
// - enable pulse starts at least 100 ns after output reaches programming level.
// - enable held 9 to 11 us, nominally 10 us.
// - command 10.5 to 11.5 V programming supply and output level.
// - elevated supply on at most 25 percent of the time; the code adds no cool-down after the last pulse of a request.
// - after each pulse read the bit at low and at high verify supply.
// - verify supply 4.0 V low and 6.0 V high.
// - repeat pulses, at most 10, until verification shows the bit blown.
// - after a good verify apply 5 more pulses to the same bit.
// - on a board enable only the target prom and drive only target output.
// - asynchronous registered variant uses the same sequence.
// - synchronous registered variant needs its enable clocked in to start and end pulse.
// ************************************************************
module fuse_prom_program_sequencer (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [prom_prog_pkg::ADDR_W-1:0] target_addr,
    input wire logic [prom_prog_pkg::BIT_W-1:0] target_bit,
    input wire logic sync_variant,
    output logic busy,
    output logic done,
    output logic fail,
    output logic [prom_prog_pkg::PULSE_W-1:0] pulses_used,
    output logic [prom_prog_pkg::ADDR_W-1:0] prom_addr,
    output logic prom_enable,
    output logic prom_clock,
    output logic [1:0] supply_level,
    output logic [prom_prog_pkg::DATA_W-1:0] output_programming_level,
    input wire logic [prom_prog_pkg::DATA_W-1:0] prom_data
);
    // ************************************************************
    // reset release and input synchronisers
    // ************************************************************
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // prom outputs settle on their own schedule, so they pass two flops before use
    logic [prom_prog_pkg::DATA_W-1:0] data_meta;
    logic [prom_prog_pkg::DATA_W-1:0] data_sync;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_meta <= '0;
            data_sync <= '0;
        end else begin
            data_meta <= prom_data;
            data_sync <= data_meta;
        end
    end

    // ************************************************************
    // state and counters
    // ************************************************************
    prom_prog_pkg::state_t state;
    prom_prog_pkg::state_t next_state;
    logic [prom_prog_pkg::CNT_W-1:0] timer;
    logic [prom_prog_pkg::CNT_W-1:0] next_timer;
    logic [prom_prog_pkg::PULSE_W-1:0] extra_cnt;
    logic [prom_prog_pkg::ADDR_W-1:0] addr_q;
    logic [prom_prog_pkg::BIT_W-1:0] bit_q;
    logic sync_q;
    logic blown_lo;
    logic blown_hi;
    logic verified;

    // a step lasts its count plus one cycle, so every minimum delay is met with margin
    wire timer_done = (timer == '0);
    // a blown bit reads high at both verify supplies
    wire bit_read = data_sync[bit_q];
    wire both_ok = blown_lo & blown_hi;
    wire out_of_pulses = (pulses_used >= prom_prog_pkg::MAX_PULSES);
    wire extra_done = (extra_cnt >= prom_prog_pkg::EXTRA_PULSES);
    wire [prom_prog_pkg::DATA_W-1:0] bit_onehot = prom_prog_pkg::DATA_W'(1) << bit_q;

    always_comb begin
        next_state = state;
        next_timer = timer_done ? '0 : timer - 16'h0_001;
        case (state)
            prom_prog_pkg::ST_IDLE: begin
                next_timer = prom_prog_pkg::STEP_CYCLES;
                if (start) begin
                    next_state = prom_prog_pkg::ST_ADDR;
                end
            end
            prom_prog_pkg::ST_ADDR: begin
                if (timer_done) begin
                    next_state = prom_prog_pkg::ST_VCC_UP;
                    next_timer = prom_prog_pkg::STEP_CYCLES;
                end
            end
            prom_prog_pkg::ST_VCC_UP: begin
                if (timer_done) begin
                    next_state = prom_prog_pkg::ST_OUT_UP;
                    next_timer = prom_prog_pkg::STEP_CYCLES;
                end
            end
            prom_prog_pkg::ST_OUT_UP: begin
                if (timer_done) begin
                    next_state = prom_prog_pkg::ST_PULSE;
                    next_timer = prom_prog_pkg::PULSE_CYCLES;
                end
            end
            prom_prog_pkg::ST_PULSE: begin
                if (timer_done) begin
                    next_state = prom_prog_pkg::ST_OUT_DN;
                    next_timer = prom_prog_pkg::STEP_CYCLES;
                end
            end
            prom_prog_pkg::ST_OUT_DN: begin
                if (timer_done) begin
                    next_state = prom_prog_pkg::ST_VCC_DN;
                    next_timer = prom_prog_pkg::STEP_CYCLES;
                end
            end
            prom_prog_pkg::ST_VCC_DN: begin
                if (timer_done) begin
                    next_state = prom_prog_pkg::ST_VFY_LO;
                    next_timer = prom_prog_pkg::STEP_CYCLES;
                end
            end
            prom_prog_pkg::ST_VFY_LO: begin
                if (timer_done) begin
                    next_state = prom_prog_pkg::ST_VFY_HI;
                    next_timer = prom_prog_pkg::STEP_CYCLES;
                end
            end
            prom_prog_pkg::ST_VFY_HI: begin
                if (timer_done) begin
                    next_state = prom_prog_pkg::ST_DECIDE;
                end
            end
            prom_prog_pkg::ST_DECIDE: begin
                // every pulse except the last of a request is followed by a cool-down so the raised supply stays under a quarter
                next_timer = prom_prog_pkg::COOL_CYCLES;
                if (verified && extra_done) begin
                    next_state = prom_prog_pkg::ST_DONE;
                end else if (!verified && !both_ok && out_of_pulses) begin
                    next_state = prom_prog_pkg::ST_DONE;
                end else begin
                    next_state = prom_prog_pkg::ST_COOL;
                end
            end
            prom_prog_pkg::ST_COOL: begin
                if (timer_done) begin
                    next_state = prom_prog_pkg::ST_VCC_UP;
                    next_timer = prom_prog_pkg::STEP_CYCLES;
                end
            end
            prom_prog_pkg::ST_DONE: begin
                next_state = prom_prog_pkg::ST_IDLE;
            end
            default: begin
                next_state = prom_prog_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= prom_prog_pkg::ST_IDLE;
            timer <= '0;
        end else begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    // ************************************************************
    // request capture, verify results, pulse counting
    // ************************************************************
    wire in_idle = (state == prom_prog_pkg::ST_IDLE);
    wire in_decide = (state == prom_prog_pkg::ST_DECIDE);
    wire pulse_end = (state == prom_prog_pkg::ST_PULSE) && timer_done;
    // sample at the end of each verify window so the read has settled
    wire lo_sample = (state == prom_prog_pkg::ST_VFY_LO) && timer_done;
    wire hi_sample = (state == prom_prog_pkg::ST_VFY_HI) && timer_done;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= '0;
            bit_q <= '0;
            sync_q <= 1'b0;
        end else if (in_idle && start) begin
            addr_q <= target_addr;
            bit_q <= target_bit;
            sync_q <= sync_variant;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            blown_lo <= 1'b0;
            blown_hi <= 1'b0;
        end else if (lo_sample) begin
            // both results are refreshed before every decide, so an earlier request never counts
            blown_lo <= bit_read;
        end else if (hi_sample) begin
            blown_hi <= bit_read;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulses_used <= '0;
            extra_cnt <= '0;
            verified <= 1'b0;
        end else if (in_idle && start) begin
            pulses_used <= '0;
            extra_cnt <= '0;
            verified <= 1'b0;
        end else if (pulse_end) begin
            // extra pulses are counted apart so pulses_used reports only the main ones
            if (verified) begin
                extra_cnt <= extra_cnt + 4'h0_001;
            end else begin
                pulses_used <= pulses_used + 4'h0_001;
            end
        end else if (in_decide && both_ok) begin
            verified <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
            fail <= 1'b0;
        end else if (in_idle && start) begin
            done <= 1'b0;
            fail <= 1'b0;
        end else if (state == prom_prog_pkg::ST_DONE) begin
            // done and fail stand until the next accepted request
            done <= 1'b1;
            fail <= ~verified;
        end
    end

    // ************************************************************
    // pin drive
    // ************************************************************
    wire supply_high = (state == prom_prog_pkg::ST_VCC_UP) || (state == prom_prog_pkg::ST_OUT_UP) ||
                       (state == prom_prog_pkg::ST_PULSE) || (state == prom_prog_pkg::ST_OUT_DN);
    wire out_high = (state == prom_prog_pkg::ST_OUT_UP) || (state == prom_prog_pkg::ST_PULSE);
    wire pulse_on = (state == prom_prog_pkg::ST_PULSE);
    wire verifying = (state == prom_prog_pkg::ST_VFY_LO) || (state == prom_prog_pkg::ST_VFY_HI);
    wire out_up_last = (state == prom_prog_pkg::ST_OUT_UP) && timer_done;
    wire pulse_first = pulse_on && (timer == prom_prog_pkg::PULSE_CYCLES);
    wire pulse_body = pulse_on && (timer > 16'h0_001);
    // plain parts see the enable pin directly for the whole pulse
    wire plain_enable = !sync_q && pulse_on;
    // registered parts: enable moves one cycle before each tick, so the part
    // always latches a settled level
    wire reg_enable = sync_q && (out_up_last || pulse_body);
    // start tick latches enable high, end tick latches it low, one pulse width apart
    wire edge_tick = sync_q && (pulse_first || pulse_end);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            // pins park at normal levels in reset so no fuse ever sees programming voltage
            prom_addr <= '0;
            prom_enable <= 1'b0;
            prom_clock <= 1'b0;
            supply_level <= prom_prog_pkg::SUPPLY_NORMAL;
            output_programming_level <= '0;
        end else begin
            prom_addr <= addr_q;
            // verify reads enable the part too; supply sits at a verify level then, so nothing blows
            prom_enable <= plain_enable || reg_enable || verifying;
            prom_clock <= edge_tick;
            if (supply_high) begin
                supply_level <= prom_prog_pkg::SUPPLY_PROGRAM;
            end else if (state == prom_prog_pkg::ST_VFY_LO) begin
                supply_level <= prom_prog_pkg::SUPPLY_VERIFY_LOW;
            end else if (state == prom_prog_pkg::ST_VFY_HI) begin
                supply_level <= prom_prog_pkg::SUPPLY_VERIFY_HIGH;
            end else begin
                supply_level <= prom_prog_pkg::SUPPLY_NORMAL;
            end
            // only the target output is raised, others left open
            output_programming_level <= out_high ? bit_onehot : '0;
        end
    end

    // busy comes straight from state, so a second request is refused from the next cycle on
    assign busy = ~in_idle;
endmodule

// ---- testbench/prom_prog_asserts.sv ----
// port assertions for the fuse prom programming sequencer
module prom_prog_asserts (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic sync_variant,
    input wire logic busy,
    input wire logic done,
    input wire logic fail,
    input wire logic [prom_prog_pkg::PULSE_W-1:0] pulses_used,
    input wire logic [prom_prog_pkg::ADDR_W-1:0] prom_addr,
    input wire logic prom_enable,
    input wire logic [1:0] supply_level,
    input wire logic [prom_prog_pkg::DATA_W-1:0] output_programming_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // helper: length of the blowing condition, plain variant only
    // ************************************************************
    wire opl_on = |output_programming_level;
    wire hot = prom_enable && supply_level == 2'h1 && opl_on && !sync_variant;
    logic [15:0] en_cnt;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            en_cnt <= 16'h0000;
        end else begin
            en_cnt <= hot ? en_cnt + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    // ************************************************************
    // properties
    // ************************************************************
    property p_one_output;
        !opl_on || $onehot(output_programming_level);
    endproperty
    a_one_output: assert property (p_one_output) else $error("more than one output raised");
    property p_out_needs_supply;
        opl_on |-> supply_level == 2'h1;
    endproperty
    a_out_needs_supply: assert property (p_out_needs_supply) else $error("output raised without supply");
    property p_supply_leads_out;
        $rose(opl_on) |-> $past(supply_level, 4) == 2'h1;
    endproperty
    a_supply_leads_out: assert property (p_supply_leads_out) else $error("output raised too soon");
    property p_out_leads_enable;
        $rose(prom_enable) && opl_on && !sync_variant |-> $past(opl_on, 4);
    endproperty
    a_out_leads_enable: assert property (p_out_leads_enable) else $error("enable too soon after output");
    property p_pulse_width;
        $fell(hot) |-> $past(en_cnt) inside {[16'h0168:16'h01B8]};
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("program pulse width out of range");
    property p_out_drops_first;
        $past(supply_level) == 2'h1 && supply_level != 2'h1 |-> !$past(opl_on, 4);
    endproperty
    a_out_drops_first: assert property (p_out_drops_first) else $error("supply dropped before output");
    property p_addr_held;
        supply_level != 2'h0 |-> $stable(prom_addr);
    endproperty
    a_addr_held: assert property (p_addr_held) else $error("address moved at raised supply");
    property p_verify_quiet;
        supply_level[1] |-> !opl_on;
    endproperty
    a_verify_quiet: assert property (p_verify_quiet) else $error("output raised during verify");
    property p_fail_count;
        done && fail |-> pulses_used == prom_prog_pkg::MAX_PULSES;
    endproperty
    a_fail_count: assert property (p_fail_count) else $error("failure before all pulses");
    property p_done_count;
        done && !fail |-> pulses_used inside {[4'h1:4'hA]};
    endproperty
    a_done_count: assert property (p_done_count) else $error("pulse count out of range");
    property p_busy_take;
        start && !busy |=> busy;
    endproperty
    a_busy_take: assert property (p_busy_take) else $error("request not taken");
endmodule

bind fuse_prom_program_sequencer prom_prog_asserts u_prom_prog_asserts (.ref_clk, .reset_n, .start,
    .sync_variant, .busy, .done, .fail, .pulses_used, .prom_addr, .prom_enable, .supply_level,
    .output_programming_level);

// ---- testbench/prom_model.sv ----
// behavioural fuse prom with pulse and supply duty bookkeeping
module prom_model (
    input wire logic ref_clk,
    input wire logic clr,
    input wire logic sync_mode,
    input wire logic [3:0] need,
    input wire logic [prom_prog_pkg::ADDR_W-1:0] prom_addr,
    input wire logic prom_enable,
    input wire logic prom_clock,
    input wire logic [1:0] supply_level,
    input wire logic [prom_prog_pkg::DATA_W-1:0] output_programming_level,
    output logic [prom_prog_pkg::DATA_W-1:0] prom_data,
    output logic [4:0] pulse_count,
    output logic [7:0] duty_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [prom_prog_pkg::DATA_W-1:0] mem [0:2**prom_prog_pkg::ADDR_W-1];
    logic [prom_prog_pkg::DATA_W-1:0] last = 8'h00;
    logic en_reg = 1'b0;
    logic blow_d = 1'b0;
    logic sup_d = 1'b0;
    logic [15:0] run_len = 16'h0000;
    logic [15:0] hi_len = 16'h0000;
    wire sup_hi = supply_level == 2'h1;
    wire en_eff = sync_mode ? en_reg : prom_enable;
    wire blow = en_eff && sup_hi && output_programming_level != 8'h00;
    wire rd_en = prom_enable && supply_level[1];
    // released outputs toggle so a stale value is never mistaken for data
    assign prom_data = rd_en ? mem[prom_addr] : ~last;
    initial begin
        for (int i = 0; i < 2**prom_prog_pkg::ADDR_W; i++) mem[i] = 8'h00;
    end
    always @(posedge ref_clk) begin
        last <= prom_data;
        blow_d <= blow;
        sup_d <= sup_hi;
        if (prom_clock) en_reg <= prom_enable;
        if (clr) begin
            pulse_count <= 5'h00;
            duty_bad <= 8'h00;
            run_len <= 16'h0000;
            hi_len <= 16'h0000;
        end else begin
            run_len <= run_len + 16'h0001;
            hi_len <= hi_len + {15'h0000, sup_hi};
            if (sup_hi && !sup_d) begin
                if (run_len != 16'h0000 && {hi_len, 2'h0} > {2'h0, run_len}) duty_bad <= duty_bad + 8'h01;
                run_len <= 16'h0001;
                hi_len <= 16'h0001;
            end
            if (blow && !blow_d) begin
                pulse_count <= pulse_count + 5'h01;
                if (need != 4'h0 && pulse_count + 5'h01 >= {1'b0, need}) begin
                    mem[prom_addr] <= mem[prom_addr] | output_programming_level;
                end
            end
        end
    end
endmodule

// ---- testbench/fuse_prom_program_sequencer_test.sv ----
// self-checking bench for the fuse prom programming sequencer
module fuse_prom_program_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic start = 1'b0;
    logic [prom_prog_pkg::ADDR_W-1:0] target_addr = 12'h000;
    logic [prom_prog_pkg::BIT_W-1:0] target_bit = 3'h0;
    logic sync_variant = 1'b0;
    logic clr = 1'b1;
    logic [3:0] need = 4'h0;
    logic busy, done, fail, prom_enable, prom_clock;
    logic [3:0] pulses_used;
    logic [11:0] prom_addr;
    logic [1:0] supply_level;
    logic [7:0] opl, prom_data, duty_bad;
    logic [4:0] pulse_count;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    always #12.5 ref_clk = ~ref_clk;
    fuse_prom_program_sequencer u_fuse_prom_program_sequencer (.ref_clk, .reset_n, .start, .target_addr,
        .target_bit, .sync_variant, .busy, .done, .fail, .pulses_used, .prom_addr, .prom_enable,
        .prom_clock, .supply_level, .output_programming_level(opl), .prom_data);
    prom_model u_prom_model (.ref_clk, .clr, .sync_mode(sync_variant), .need, .prom_addr, .prom_enable,
        .prom_clock, .supply_level, .output_programming_level(opl), .prom_data, .pulse_count, .duty_bad);
    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic final_report();
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one request; intrude fires a second start while busy, which must be ignored
    task automatic program_bit(input logic [11:0] a, input logic [2:0] b, input logic s, input logic [3:0] n,
                               input logic intrude);
        int w;
        @(posedge ref_clk);
        #2;
        clr = 1'b1;
        @(posedge ref_clk);
        #2;
        clr = 1'b0;
        need = n;
        target_addr = a;
        target_bit = b;
        sync_variant = s;
        start = 1'b1;
        @(posedge ref_clk);
        #2;
        start = 1'b0;
        if (intrude) begin
            repeat (30) @(posedge ref_clk);
            #2;
            target_addr = 12'h123;
            start = 1'b1;
            @(posedge ref_clk);
            #2;
            start = 1'b0;
        end
        w = 0;
        while (done !== 1'b1 && w < 20000) begin
            @(posedge ref_clk);
            #2;
            w++;
        end
        check("done", 8'h01, {7'h00, done});
        check("duty violations", 8'h00, duty_bad);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic scn_first_pulse();
        program_bit(12'h000, 3'h0, 1'b0, 4'h1, 1'b0);
        check("fail", 8'h00, {7'h00, fail});
        check("pulses_used", 8'h01, {4'h0, pulses_used});
        check("pulses seen", 8'h06, {3'h0, pulse_count});
        check("word 000", 8'h01, u_prom_model.mem[12'h000]);
    endtask
    task automatic scn_never_blows();
        program_bit(12'hFFF, 3'h7, 1'b0, 4'h0, 1'b0);
        check("fail", 8'h01, {7'h00, fail});
        check("pulses_used", 8'h0A, {4'h0, pulses_used});
        check("pulses seen", 8'h0A, {3'h0, pulse_count});
        check("word fff", 8'h00, u_prom_model.mem[12'hFFF]);
    endtask
    task automatic scn_sync_variant();
        program_bit(12'h5A3, 3'h4, 1'b1, 4'h3, 1'b0);
        check("fail", 8'h00, {7'h00, fail});
        check("pulses_used", 8'h03, {4'h0, pulses_used});
        check("pulses seen", 8'h08, {3'h0, pulse_count});
        check("word 5a3", 8'h10, u_prom_model.mem[12'h5A3]);
    endtask
    task automatic scn_refused_start();
        program_bit(12'h7FE, 3'h7, 1'b0, 4'h2, 1'b1);
        check("pulses_used", 8'h02, {4'h0, pulses_used});
        check("pulses seen", 8'h07, {3'h0, pulse_count});
        check("word 7fe", 8'h80, u_prom_model.mem[12'h7FE]);
        check("word 123", 8'h00, u_prom_model.mem[12'h123]);
    endtask
    // ************************************************************
    // timeout and main sequence
    // ************************************************************
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 70000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        #2;
        reset_n = 1'b1;
        repeat (5) @(posedge ref_clk);
        scn_first_pulse();
        scn_never_blows();
        scn_sync_variant();
        scn_refused_start();
        final_report();
    end
endmodule
